// ---- rtl/lsrc_pkg.sv ----
// Purpose: shared constants and types of the LCD refresh controller
// Assumes: APB register map, 100 MHz pclk
// Notes:   field positions are bit indices inside each register word
package lsrc_pkg;
    localparam logic [11:0] A_START  = 12'h000;
    localparam logic [11:0] A_VPW    = 12'h004;
    localparam logic [11:0] A_WIDTH  = 12'h008;
    localparam logic [11:0] A_HEIGHT = 12'h00C;
    localparam logic [11:0] A_CPOS   = 12'h010;
    localparam logic [11:0] A_CSIZE  = 12'h014;
    localparam logic [11:0] A_BLINK  = 12'h018;
    localparam logic [11:0] A_PAL    = 12'h01C;
    localparam logic [11:0] A_CLKCTL = 12'h020;
    localparam logic [11:0] A_SREF   = 12'h024;
    localparam logic [11:0] A_STATUS = 12'h028;

    localparam int CPOS_Y_LSB   = 16;
    localparam int CSIZE_H_LSB  = 8;
    localparam int CSIZE_M_LSB  = 16;
    localparam int BLINK_EN_BIT = 7;
    localparam int PAL_HI_LSB   = 4;
    localparam int CLK_EN_BIT   = 7;
    localparam int CLK_GRAY_BIT = 0;
    localparam int SREF_BIT     = 7;

    // pclk cycles per half shift-clock period
    localparam logic [2:0] PIX_HALF_CYCLES = 3'h4;
    // Line pulse length in half shift-clock periods
    localparam logic [1:0] LP_TICKS = 2'h2;
    localparam int LBUF_WORDS = 80;

    // Density numerators and denominators, gray code F first
    localparam logic [15:0][3:0] FRC_NUM = {4'h1, 4'hE, 4'h7, 4'h4,
        4'h3, 4'h2, 4'h3, 4'h5, 4'h1, 4'h4, 4'h2, 4'h1,
        4'h1, 4'h1, 4'h1, 4'h0};
    localparam logic [15:0][3:0] FRC_DEN = {4'h1, 4'hF, 4'h8, 4'h5,
        4'h4, 4'h3, 4'h5, 4'h9, 4'h2, 4'h9, 4'h5, 4'h3,
        4'h4, 4'h5, 4'h8, 4'h1};

    typedef enum logic [1:0] {
        CUR_OFF, CUR_BLACK, CUR_REVERSE, CUR_WHITE
    } lsrc_cmode_e;

    typedef enum {P_OFF, P_WAIT, P_SHIFT, P_PULSE} lsrc_pstate_e;
    typedef enum {D_IDLE, D_REQ, D_READ} lsrc_dstate_e;

    typedef struct packed {
        logic [31:0] start_addr;
        logic [7:0]  vpw;
        logic [9:0]  width;
        logic [9:0]  height;
        logic [9:0]  cur_x;
        logic [9:0]  cur_y;
        logic [4:0]  cur_w;
        logic [4:0]  cur_h;
        lsrc_cmode_e cur_mode;
        logic        blink_en;
        logic [6:0]  blink_div;
        logic [3:0]  pal_lo;
        logic [3:0]  pal_hi;
        logic        enable;
        logic        gray;
        logic        self_refresh;
    } lsrc_cfg_s;

    localparam lsrc_cfg_s CFG_RESET = '0;

    typedef struct packed {
        logic [31:0] addr;
        logic        rd;
    } lsrc_dma_s;
endpackage

// ---- rtl/lsrc_top.sv ----
// Purpose: LCD screen refresh controller with line DMA, cursor and FRC
// Assumes: single pclk domain; memory answers reads with dma_rvalid
// Notes:   one burst per line keeps screen DMA spread over the frame
`timescale 1ns/1ps
`default_nettype none
module lsrc_top (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              clk_en,
    input  wire logic [11:0]       paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   bus_request,
    input  wire logic              bus_grant,
    output lsrc_pkg::lsrc_dma_s    dma_req,
    input  wire logic [15:0]       dma_rdata,
    input  wire logic              dma_rvalid,
    output logic                   panel_shift_clock,
    output logic                   panel_data_bus,
    output logic                   panel_line_pulse,
    output logic                   panel_frame_marker
);
    lsrc_pkg::lsrc_cfg_s    cfg;
    lsrc_pkg::lsrc_pstate_e pst;
    lsrc_pkg::lsrc_dstate_e dst;
    logic [9:0]  horizontal_pixel_counter;
    logic [9:0]  vertical_line_counter;
    logic [2:0]  tdiv;
    logic        phase;
    logic [1:0]  lp_cnt;
    logic        show_bank;
    logic        fill_bank;
    logic        sr_active;
    logic [31:0] dma_base;
    logic [31:0] dma_ptr;
    logic [6:0]  dma_idx;
    logic [6:0]  dma_words;
    logic [6:0]  blink_cnt;
    logic        blink_phase;
    logic [15:0] frc_on;
    logic [15:0] lbuf [0:1][0:lsrc_pkg::LBUF_WORDS-1];

    // Register bus
    logic [31:0] rd_word;
    logic [31:0] wmask;
    logic [31:0] new_word;
    logic        mapped;
    logic        wr_en;
    logic        rd_ok;
    assign rd_word =
        (paddr == lsrc_pkg::A_START)  ? cfg.start_addr :
        (paddr == lsrc_pkg::A_VPW)    ? {24'h0, cfg.vpw} :
        (paddr == lsrc_pkg::A_WIDTH)  ? {22'h0, cfg.width} :
        (paddr == lsrc_pkg::A_HEIGHT) ? {22'h0, cfg.height} :
        (paddr == lsrc_pkg::A_CPOS)   ?
            {6'h0, cfg.cur_y, 6'h0, cfg.cur_x} :
        (paddr == lsrc_pkg::A_CSIZE)  ?
            {14'h0, cfg.cur_mode, 3'h0, cfg.cur_h, 3'h0, cfg.cur_w} :
        (paddr == lsrc_pkg::A_BLINK)  ?
            {24'h0, cfg.blink_en, cfg.blink_div} :
        (paddr == lsrc_pkg::A_PAL)    ? {24'h0, cfg.pal_hi, cfg.pal_lo} :
        (paddr == lsrc_pkg::A_CLKCTL) ?
            {24'h0, cfg.enable, 6'h0, cfg.gray} :
        (paddr == lsrc_pkg::A_SREF)   ? {24'h0, cfg.self_refresh, 7'h0} :
        (paddr == lsrc_pkg::A_STATUS) ?
            {13'h0, pst != lsrc_pkg::P_OFF, dst != lsrc_pkg::D_IDLE,
             sr_active, 6'h0, vertical_line_counter} :
        32'h0;
    assign mapped = (paddr[1:0] == 2'h0) && (paddr <= lsrc_pkg::A_STATUS);
    assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}},
                    {8{pstrb[1]}}, {8{pstrb[0]}}};
    assign new_word = (rd_word & ~wmask) | (pwdata & wmask);
    assign pready = clk_en && rd_ok;
    assign pslverr = psel && penable && !mapped;
    assign wr_en = psel && penable && pwrite && mapped && pready;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            rd_ok <= 1'b0;
        end else if (clk_en) begin
            rd_ok <= psel && !(penable && rd_ok);
            if (psel && !rd_ok) prdata <= mapped ? rd_word : 32'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= lsrc_pkg::CFG_RESET;
        end else if (wr_en) begin
            case (paddr)
                lsrc_pkg::A_START:  cfg.start_addr <= {new_word[31:1], 1'b0};
                lsrc_pkg::A_VPW:    cfg.vpw <= new_word[7:0];
                lsrc_pkg::A_WIDTH:  cfg.width <= new_word[9:0];
                lsrc_pkg::A_HEIGHT: cfg.height <= new_word[9:0];
                lsrc_pkg::A_CPOS: begin
                    cfg.cur_x <= new_word[9:0];
                    cfg.cur_y <= new_word[lsrc_pkg::CPOS_Y_LSB +: 10];
                end
                lsrc_pkg::A_CSIZE: begin
                    cfg.cur_w <= new_word[4:0];
                    cfg.cur_h <= new_word[lsrc_pkg::CSIZE_H_LSB +: 5];
                    cfg.cur_mode <= lsrc_pkg::lsrc_cmode_e'(
                        new_word[lsrc_pkg::CSIZE_M_LSB +: 2]);
                end
                lsrc_pkg::A_BLINK: begin
                    cfg.blink_div <= new_word[6:0];
                    cfg.blink_en <= new_word[lsrc_pkg::BLINK_EN_BIT];
                end
                lsrc_pkg::A_PAL: begin
                    cfg.pal_lo <= new_word[3:0];
                    cfg.pal_hi <= new_word[lsrc_pkg::PAL_HI_LSB +: 4];
                end
                lsrc_pkg::A_CLKCTL: begin
                    cfg.enable <= new_word[lsrc_pkg::CLK_EN_BIT];
                    cfg.gray <= new_word[lsrc_pkg::CLK_GRAY_BIT];
                end
                lsrc_pkg::A_SREF:
                    cfg.self_refresh <= new_word[lsrc_pkg::SREF_BIT];
                default: ;
            endcase
        end
    end

    // Timing and scan decode
    logic        tick;
    logic        last_line;
    logic        last_pix;
    logic        pulse_done;
    logic        frame_end;
    logic        dma_idle;
    logic        dma_go;
    logic [31:0] dma_go_addr;
    logic [31:0] line_step;
    logic [6:0]  line_words;
    assign tick = tdiv == (lsrc_pkg::PIX_HALF_CYCLES - 3'h1);
    assign last_line = vertical_line_counter == (cfg.height - 10'h1);
    assign last_pix = horizontal_pixel_counter == (cfg.width - 10'h1);
    assign pulse_done = (pst == lsrc_pkg::P_PULSE) && tick &&
                        (lp_cnt == (lsrc_pkg::LP_TICKS - 2'h1));
    assign frame_end = pulse_done && last_line;
    assign dma_idle = dst == lsrc_pkg::D_IDLE;
    assign line_step = {23'h0, cfg.vpw, 1'b0};
    assign line_words = cfg.gray ? cfg.width[9:3] : {1'b0, cfg.width[9:4]};
    // One launch per line, if enabled
    assign dma_go = cfg.enable &&
        ((pst == lsrc_pkg::P_OFF) || ((pst == lsrc_pkg::P_WAIT) && dma_idle));
    // First line of each frame from start address
    assign dma_go_addr = ((pst == lsrc_pkg::P_OFF) || last_line) ?
                         cfg.start_addr : dma_base + line_step;

    // Screen DMA, one burst per line
    // Request held until burst ends
    assign bus_request = !dma_idle;
    assign dma_req.rd = dst == lsrc_pkg::D_READ;
    assign dma_req.addr = dma_ptr;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dst <= lsrc_pkg::D_IDLE;
            dma_base <= 32'h0;
            dma_ptr <= 32'h0;
            dma_idx <= 7'h0;
            dma_words <= 7'h0;
        end else if (clk_en) begin
            case (dst)
                lsrc_pkg::D_IDLE: begin
                    if (dma_go && (line_words != 7'h0)) begin
                        dst <= lsrc_pkg::D_REQ;
                        dma_base <= dma_go_addr;
                        dma_ptr <= dma_go_addr;
                        dma_idx <= 7'h0;
                        dma_words <= line_words;
                    end
                end
                lsrc_pkg::D_REQ: begin
                    if (bus_grant) begin
                        dst <= lsrc_pkg::D_READ;
                    end
                end
                lsrc_pkg::D_READ: begin
                    if (dma_rvalid) begin
                        dma_idx <= dma_idx + 7'h1;
                        dma_ptr <= dma_ptr + 32'h2;
                        if (dma_idx == (dma_words - 7'h1)) begin
                            dst <= lsrc_pkg::D_IDLE;
                        end
                    end
                end
                default: dst <= lsrc_pkg::D_IDLE;
            endcase
        end
    end

    // Fly-by data straight into line buffer
    always_ff @(posedge pclk) begin
        if (clk_en && dma_req.rd && dma_rvalid) begin
            lbuf[fill_bank][dma_idx] <= dma_rdata;
        end
    end

    // Pixel pick, cursor and gray mapping
    logic [6:0]  widx;
    logic [15:0] word;
    logic [15:0] sh2;
    logic [15:0] sh1;
    logic [1:0]  pv;
    logic [1:0]  cv;
    logic [3:0]  code;
    logic [4:0]  cw;
    logic [4:0]  ch;
    logic        in_cur;
    logic        cur_show;
    logic        pix_on;
    assign widx = cfg.gray ? horizontal_pixel_counter[9:3] :
                  {1'b0, horizontal_pixel_counter[9:4]};
    assign word = lbuf[show_bank][widx];
    assign sh2 = word << {horizontal_pixel_counter[2:0], 1'b0};
    assign sh1 = word << horizontal_pixel_counter[3:0];
    // One bit maps to full off or full on
    assign pv = cfg.gray ? sh2[15:14] : {2{sh1[15]}};
    // Zero size taken as one pixel
    assign cw = (cfg.cur_w == 5'h0) ? 5'h1 : cfg.cur_w;
    assign ch = (cfg.cur_h == 5'h0) ? 5'h1 : cfg.cur_h;
    assign in_cur =
        (horizontal_pixel_counter >= cfg.cur_x) &&
        ({1'b0, horizontal_pixel_counter} < ({1'b0, cfg.cur_x} + 11'(cw))) &&
        (vertical_line_counter >= cfg.cur_y) &&
        ({1'b0, vertical_line_counter} < ({1'b0, cfg.cur_y} + 11'(ch)));
    assign cur_show = in_cur && (!cfg.blink_en || blink_phase);
    assign cv = !cur_show ? pv :
        (cfg.cur_mode == lsrc_pkg::CUR_BLACK)   ? 2'h3 :
        (cfg.cur_mode == lsrc_pkg::CUR_REVERSE) ? ~pv :
        (cfg.cur_mode == lsrc_pkg::CUR_WHITE)   ? 2'h0 : pv;
    assign code = (cv == 2'h0) ? 4'h0 :
                  (cv == 2'h1) ? cfg.pal_lo :
                  (cv == 2'h2) ? cfg.pal_hi : 4'hF;
    assign pix_on = frc_on[code];

    for (genvar g = 0; g < 16; g++) begin : g_frc
        logic [3:0] acc;
        wire  [4:0] sum = {1'b0, acc} + {1'b0, lsrc_pkg::FRC_NUM[g]};
        assign frc_on[g] = sum >= {1'b0, lsrc_pkg::FRC_DEN[g]};
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                acc <= 4'h0;
            end else if (clk_en && frame_end) begin
                acc <= frc_on[g] ?
                    4'(sum - {1'b0, lsrc_pkg::FRC_DEN[g]}) : sum[3:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blink_cnt <= 7'h0;
            blink_phase <= 1'b0;
        end else if (clk_en && frame_end) begin
            if (blink_cnt >= cfg.blink_div) begin
                blink_cnt <= 7'h0;
                blink_phase <= !blink_phase;
            end else begin
                blink_cnt <= blink_cnt + 7'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tdiv <= 3'h0;
        end else if (clk_en) begin
            tdiv <= tick ? 3'h0 : tdiv + 3'h1;
        end
    end

    // Panel scan
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pst <= lsrc_pkg::P_OFF;
            horizontal_pixel_counter <= 10'h0;
            vertical_line_counter <= 10'h0;
            phase <= 1'b0;
            lp_cnt <= 2'h0;
            show_bank <= 1'b0;
            fill_bank <= 1'b0;
            sr_active <= 1'b0;
            panel_shift_clock <= 1'b0;
            panel_data_bus <= 1'b0;
            panel_line_pulse <= 1'b0;
            panel_frame_marker <= 1'b0;
        end else if (clk_en) begin
            case (pst)
                lsrc_pkg::P_OFF: begin
                    panel_shift_clock <= 1'b0;
                    panel_data_bus <= 1'b0;
                    panel_line_pulse <= 1'b0;
                    if (cfg.enable) begin
                        pst <= lsrc_pkg::P_WAIT;
                        vertical_line_counter <= 10'h0;
                        fill_bank <= 1'b0;
                        sr_active <= cfg.self_refresh;
                    end
                end
                lsrc_pkg::P_WAIT: begin
                    if (dma_idle) begin
                        if (!cfg.enable) begin
                            pst <= lsrc_pkg::P_OFF;
                        end else begin
                            pst <= lsrc_pkg::P_SHIFT;
                            show_bank <= fill_bank;
                            fill_bank <= !fill_bank;
                            horizontal_pixel_counter <= 10'h0;
                            phase <= 1'b0;
                        end
                    end
                end
                lsrc_pkg::P_SHIFT: begin
                    if (tick && !phase) begin
                        phase <= 1'b1;
                        panel_shift_clock <= 1'b0;
                        panel_data_bus <= !sr_active && pix_on;
                    end else if (tick) begin
                        phase <= 1'b0;
                        panel_shift_clock <= !sr_active;
                        if (last_pix) begin
                            pst <= lsrc_pkg::P_PULSE;
                            lp_cnt <= 2'h0;
                            panel_line_pulse <= 1'b1;
                            if (vertical_line_counter == 10'h0) begin
                                panel_frame_marker <= 1'b0;
                            end
                        end else begin
                            horizontal_pixel_counter <=
                                horizontal_pixel_counter + 10'h1;
                        end
                    end
                end
                lsrc_pkg::P_PULSE: begin
                    if (tick) begin
                        lp_cnt <= lp_cnt + 2'h1;
                        panel_shift_clock <= 1'b0;
                        panel_data_bus <= 1'b0;
                    end
                    if (pulse_done) begin
                        panel_line_pulse <= 1'b0;
                        horizontal_pixel_counter <= 10'h0;
                        pst <= lsrc_pkg::P_WAIT;
                        if (last_line) begin
                            panel_frame_marker <= 1'b1;
                            vertical_line_counter <= 10'h0;
                            // Mode changes only at frame end or on leaving P_OFF
                            // Next frame starts at page top
                            sr_active <= cfg.self_refresh;
                        end else begin
                            vertical_line_counter <=
                                vertical_line_counter + 10'h1;
                        end
                    end
                end
                default: pst <= lsrc_pkg::P_OFF;
            endcase
        end
    end
endmodule // lsrc_top
`default_nettype wire

// ---- sim/lsrc_props.sv ----
// Purpose: port-level checker for the LCD refresh controller
// Assumes: one pclk domain, reset active low
// Notes:   attached to lsrc_top by bind below
`timescale 1ns/1ps
`default_nettype none
module lsrc_props (
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                bus_request,
    input wire logic                bus_grant,
    input wire lsrc_pkg::lsrc_dma_s dma_req,
    input wire logic                dma_rvalid,
    input wire logic                panel_shift_clock,
    input wire logic                panel_data_bus,
    input wire logic                panel_line_pulse,
    input wire logic                panel_frame_marker
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_rd_grant;
        dma_req.rd |-> bus_grant && bus_request;
    endproperty
    a_rd_grant: assert property (p_rd_grant)
        else $error("read without grant");
    property p_rd_late;
        $rose(dma_req.rd) |-> $past(bus_request) && $past(bus_grant);
    endproperty
    a_rd_late: assert property (p_rd_late)
        else $error("read before grant seen");
    property p_addr_step;
        (dma_req.rd && dma_rvalid) ##1 dma_req.rd
            |-> dma_req.addr == $past(dma_req.addr) + 32'h2;
    endproperty
    a_addr_step: assert property (p_addr_step)
        else $error("read address not stepped by 2");
    property p_addr_hold;
        dma_req.rd && !dma_rvalid |=> dma_req.rd && $stable(dma_req.addr);
    endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("read dropped before data");
    property p_sclk_half;
        $rose(panel_shift_clock) |-> panel_shift_clock[*4] ##1 !panel_shift_clock;
    endproperty
    a_sclk_half: assert property (p_sclk_half)
        else $error("shift clock high time wrong");
    property p_data_hold;
        panel_shift_clock |-> $stable(panel_data_bus);
    endproperty
    a_data_hold: assert property (p_data_hold)
        else $error("data moved while shift clock high");
    property p_lp_len;
        $rose(panel_line_pulse) |-> panel_line_pulse[*8] ##1 !panel_line_pulse;
    endproperty
    a_lp_len: assert property (p_lp_len)
        else $error("line pulse length wrong");
    property p_frm_edges;
        $changed(panel_frame_marker) |-> $changed(panel_line_pulse)
            && panel_line_pulse != panel_frame_marker;
    endproperty
    a_frm_edges: assert property (p_frm_edges)
        else $error("frame marker off line pulse edge");
endmodule // lsrc_props
bind lsrc_top lsrc_props u_props (.pclk(pclk), .presetn(presetn),
    .bus_request(bus_request), .bus_grant(bus_grant), .dma_req(dma_req),
    .dma_rvalid(dma_rvalid), .panel_shift_clock(panel_shift_clock),
    .panel_data_bus(panel_data_bus), .panel_line_pulse(panel_line_pulse),
    .panel_frame_marker(panel_frame_marker));
`default_nettype wire

// ---- sim/lsrc_mem.sv ----
// Purpose: system memory and bus arbiter model for screen DMA
// Assumes: data keyed by address, or a fixed fill word
// Notes:   slow mode delays grant and halves the read rate
`timescale 1ns/1ps
`default_nettype none
module lsrc_mem (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                slow,
    input  wire logic                fill_on,
    input  wire logic                bus_request,
    input  wire lsrc_pkg::lsrc_dma_s dma_req,
    output logic                     bus_grant,
    output logic [15:0]              dma_rdata,
    output logic                     dma_rvalid
);
    logic [15:0] last;
    logic [1:0]  cnt;
    logic        tog;
    assign dma_rvalid = dma_req.rd && (!slow || tog);
    // Undriven data shows the inverse of the last word
    assign dma_rdata = !dma_rvalid ? ~last : fill_on ? 16'h5555
        : {dma_req.addr[8:1], ~dma_req.addr[8:1]};
    assign bus_grant = bus_request && (slow ? cnt == 2'h3 : cnt != 2'h0);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 2'h0;
            tog <= 1'b0;
            last <= 16'h0;
        end else begin
            cnt <= bus_request ? cnt + {1'b0, cnt != 2'h3} : 2'h0;
            tog <= ~tog;
            last <= dma_rdata;
        end
    end
endmodule // lsrc_mem
`default_nettype wire

// ---- sim/lsrc_bench.sv ----
// Purpose: self-checking bench for the LCD refresh controller
// Assumes: 100 MHz pclk, APB master, memory model partner
// Notes:   pixels predicted from address-keyed memory data
`timescale 1ns/1ps
`default_nettype none
module lsrc_bench;
    logic        pclk = 0, presetn = 0, clk_en = 1, jit = 0, slow = 0;
    logic        psel = 0, penable = 0, pwrite = 0, fill_on = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, start, v;
    logic        pready, pslverr, bus_request, bus_grant, dma_rvalid;
    logic        sclk, pdat, lp, fm, sc_q = 0, lp_q = 0, fm_q = 0, br_q = 0;
    logic        sync = 0, chk = 0, first_pix = 0;
    logic [15:0] dma_rdata, w;
    logic [33:0] note, notes[$];
    lsrc_pkg::lsrc_dma_s dma_req;
    int fail_count = 0, n_tests = 0, seed = 8912, px = 0, ly = 0;
    int n_sc = 0, n_lp = 0, n_br = 0, vpw, mode, on;
    int num[16] = '{0, 1, 1, 1, 1, 2, 4, 1, 5, 3, 2, 3, 4, 7, 14, 1};
    int den[16] = '{1, 8, 5, 4, 3, 5, 9, 2, 9, 5, 3, 4, 5, 8, 15, 1};
    logic [31:0] mask[8] = '{32'hFFFFFFFE, 32'hFF, 32'h3FF, 32'h3FF,
        32'h03FF03FF, 32'h31F1F, 32'hFF, 32'hFF};
    lsrc_top DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus_request(bus_request), .bus_grant(bus_grant),
        .dma_req(dma_req), .dma_rdata(dma_rdata), .dma_rvalid(dma_rvalid),
        .panel_shift_clock(sclk), .panel_data_bus(pdat),
        .panel_line_pulse(lp), .panel_frame_marker(fm));
    lsrc_mem MEM (.pclk(pclk), .presetn(presetn), .slow(slow),
        .fill_on(fill_on), .bus_request(bus_request), .dma_req(dma_req),
        .bus_grant(bus_grant), .dma_rdata(dma_rdata), .dma_rvalid(dma_rvalid));
    initial forever #5 pclk = ~pclk;
    always @(posedge pclk) clk_en <= jit ? (($random(seed) & 3) != 0) : 1'b1;
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, input logic [32:0] exp);
        int n = 0;
        notes.push_back({wr, exp});
        psel <= 1'b1;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
        if (n >= 50) fail_count++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask
    task automatic frames(input int k);
        repeat (k) @(posedge fm);
    endtask
    function automatic logic pix_exp(input int x, input int y);
        logic [31:0] a;
        logic        d;
        a = start + 32'(y * vpw * 2 + (x / 16) * 2);
        w = {a[8:1], ~a[8:1]};
        d = w[15 - x % 16];
        if (x >= 3 && x < 8 && y == 1 && mode != 0)
            d = mode == 1 ? 1'b1 : mode == 2 ? ~d : 1'b0;
        return d;
    endfunction
    // Read results checked as each APB access completes
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            note = notes.pop_front();
            check(32'(pslverr), 32'(note[32]));
            if (!note[33]) check(prdata, note[31:0]);
        end
    end
    always @(posedge pclk) begin
        if (sclk && !sc_q) begin
            if (chk && sync) check(32'(pdat), 32'(pix_exp(px, ly)));
            if (px == 0 && ly == 0) first_pix = pdat;
            px++;
            n_sc++;
        end
        if (lp && !lp_q) n_lp++;
        if (bus_request && !br_q) n_br++;
        if (!lp && lp_q) px = 0;
        if (!lp && lp_q) ly++;
        if (fm && !fm_q) {ly, sync} = 1;
        {sc_q, lp_q, fm_q, br_q} = {sclk, lp, fm, bus_request};
    end
    initial begin
        #1000000;
        fail_count++;
        close_out;
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        jit <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 11; i++) apb(1'b0, 12'(4 * i), 0, 33'h0);
        for (int i = 0; i < 8; i++) begin
            v = $random(seed);
            wr(12'(4 * i), v);
            apb(1'b0, 12'(4 * i), 0, {1'b0, v & mask[i]});
        end
        apb(1'b0, 12'h02C, 0, {1'b1, 32'h0});
        apb(1'b1, 12'h006, 32'h1, {1'b1, 32'h0});
        wr(lsrc_pkg::A_STATUS, 32'hFFFFFFFF);
        apb(1'b0, lsrc_pkg::A_STATUS, 0, 33'h0);
        $display("register test done");
        jit <= 1'b0;
        // Start kept inside the page by software
        start = 32'h1000 + ($random(seed) & 32'h7FE);
        vpw = 2 + ($random(seed) & 3);
        wr(lsrc_pkg::A_START, start);
        wr(lsrc_pkg::A_VPW, vpw);
        wr(lsrc_pkg::A_WIDTH, 32);
        wr(lsrc_pkg::A_HEIGHT, 3);
        wr(lsrc_pkg::A_CPOS, 32'h00010003);
        wr(lsrc_pkg::A_BLINK, 0);
        wr(lsrc_pkg::A_CLKCTL, 32'h80);
        for (int m = 0; m < 4; m++) begin
            chk = 0;
            mode = m;
            wr(lsrc_pkg::A_CSIZE, (32'(m) << 16) | 32'h0105);
            frames(1);
            chk = 1;
            frames(2);
        end
        $display("cursor test done");
        wr(lsrc_pkg::A_CLKCTL, 32'h0);
        repeat (3000) @(posedge pclk);
        {n_sc, n_br} = 0;
        repeat (2000) @(posedge pclk);
        check(n_sc, 0);
        check(n_br, 0);
        {px, ly, sync} = 1;
        wr(lsrc_pkg::A_CLKCTL, 32'h80);
        frames(2);
        $display("power test done");
        wr(lsrc_pkg::A_SREF, 32'h80);
        frames(1);
        {n_sc, n_lp} = 0;
        frames(1);
        check(n_sc, 0);
        check(n_lp, 3);
        wr(lsrc_pkg::A_SREF, 32'h0);
        n_sc = 0;
        frames(1);
        check(n_sc, 0);
        frames(2);
        $display("self-refresh test done");
        chk = 0;
        fill_on <= 1'b1;
        slow <= 1'b1;
        wr(lsrc_pkg::A_CLKCTL, 32'h0);
        repeat (400) @(posedge pclk);
        wr(lsrc_pkg::A_CSIZE, 32'h0);
        wr(lsrc_pkg::A_WIDTH, 16);
        wr(lsrc_pkg::A_HEIGHT, 2);
        wr(lsrc_pkg::A_CLKCTL, 32'h81);
        for (int c = 0; c < 16; c++) begin
            wr(lsrc_pkg::A_PAL, 32'(c * 17));
            frames(1);
            on = 0;
            repeat (den[c]) begin
                frames(1);
                on += first_pix;
            end
            check(on, num[c]);
        end
        $display("gray test done");
        close_out;
    end
endmodule // lsrc_bench
`default_nettype wire
